// >>> hdl/cioc_regs.vh
// register offsets, field positions, codes and timing constants of the counter i/o block
`ifndef CIOC_REGS_VH
`define CIOC_REGS_VH

// register byte offsets
`define CIOC_OFS_OUT_FUNC 8'h0A
`define CIOC_OFS_OUT_DIR 8'h0B
`define CIOC_OFS_PULSE0_HI 8'h0C
`define CIOC_OFS_PULSE0_LO 8'h0D
`define CIOC_OFS_PULSE1_HI 8'h0E
`define CIOC_OFS_PULSE1_LO 8'h0F
`define CIOC_OFS_IN_BEHAV 8'h10
`define CIOC_OFS_CMD 8'h18
`define CIOC_OFS_USER_OUT 8'h19
`define CIOC_OFS_STATUS 8'h1A
`define CIOC_OFS_CAP_B3 8'h1C
`define CIOC_OFS_CAP_B2 8'h1D
`define CIOC_OFS_CAP_B1 8'h1E
`define CIOC_OFS_CAP_B0 8'h1F

// reset values
`define CIOC_RST_OUT_FUNC 8'h00
`define CIOC_RST_OUT_DIR 8'hF0
`define CIOC_RST_PULSE 16'h0000
`define CIOC_RST_IN_BEHAV 8'h26
`define CIOC_RST_BYTE 8'h00
`define CIOC_RST_WORD 32'h0000_0000

// output function codes
`define CIOC_OF_USER 4'h0
`define CIOC_OF_GE 4'h1
`define CIOC_OF_LE 4'h2
`define CIOC_OF_PULSE 4'h3
`define CIOC_OF_BETWEEN 4'h4
`define CIOC_OF_SETCLR 4'h5
`define CIOC_OF_OUTSIDE 4'h6

// count direction and edge selection
`define CIOC_DIR_RSVD 2'h0
`define CIOC_EDGE_RSVD 2'h0

// input function codes
`define CIOC_IF_LEVEL 3'h0
`define CIOC_IF_GSTART 3'h1
`define CIOC_IF_GSTOP 3'h2
`define CIOC_IF_SYNC 3'h3
`define CIOC_IF_SYNC_N 3'h4
`define CIOC_IF_CAPTURE 3'h5
`define CIOC_IF_PLAIN 3'h6
`define CIOC_IF_RSVD 3'h7

// timing: pulse duration unit and clock period
`define CIOC_TICK_NS 100000
`define CIOC_CLK_NS 100
`define CIOC_TICK_CYC (`CIOC_TICK_NS / `CIOC_CLK_NS)
`define CIOC_TICK_W 10
`define CIOC_TICK_ONE 10'h001
`define CIOC_TICK_ZERO 10'h000
`define CIOC_TICK_LAST 10'h3E7

// field positions inside the parameter bytes
`define CIOC_F_OF0 3:0
`define CIOC_F_OF1 7:4
`define CIOC_F_DIR0 5:4
`define CIOC_F_DIR1 7:6
`define CIOC_F_IFUNC 2:0
`define CIOC_F_LVL 4
`define CIOC_F_EDGE 6:5
`define CIOC_F_RELOAD 7
`define CIOC_F_PAIR 1:0
`define CIOC_F_SET0 0
`define CIOC_F_SET1 1
`define CIOC_F_HI 15:8
`define CIOC_F_LO 7:0
`define CIOC_F_B3 31:24
`define CIOC_F_B2 23:16
`define CIOC_F_B1 15:8
`define CIOC_F_B0 7:0
`define CIOC_E_RISE 0
`define CIOC_E_FALL 1
`define CIOC_RST_PAIR 2'h0
`define CIOC_STAT_PAD 6'h00

`endif

// >>> hdl/cioc_top.v
// compare outputs and first digital input of a position counter channel
`timescale 1ns/10ps
`default_nettype none
`include "cioc_regs.vh"

// --------------------------------------------------------------
// compare output channel
// --------------------------------------------------------------
module cioc_chan (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // configuration
    input wire tick,
    input wire [3:0] func,
    input wire [1:0] dir,
    input wire [15:0] dur,
    input wire user_lvl,
    input wire set_cmd,
    // counter state
    input wire [31:0] count_value,
    input wire count_up,
    input wire count_step,
    input wire [31:0] cmp_own,
    input wire [31:0] cmp_lo,
    input wire [31:0] cmp_hi,
    // output
    output wire out_q
);

    reg out_r;
    reg [15:0] left_r;
    wire dir_ok;
    wire eval;
    wire reach;
    wire in_range;

    // comparisons only count in the selected directions
    assign dir_ok = (dir[0] & count_up) | (dir[1] & ~count_up); // RL8
    assign eval = count_step & dir_ok; // RL8
    assign reach = eval & (count_value == cmp_own);
    assign in_range = (count_value >= cmp_lo) & (count_value <= cmp_hi);
    assign out_q = out_r;

    // output state per switching rule
    always @(posedge clock) begin
        if (!rst_b) begin
            out_r <= 1'b0;
            left_r <= `CIOC_RST_PULSE;
        end else begin
            case (func)
                `CIOC_OF_USER: begin
                    out_r <= user_lvl; // RL1
                    left_r <= `CIOC_RST_PULSE;
                end
                `CIOC_OF_GE: begin
                    if (eval) begin
                        out_r <= (count_value >= cmp_own); // RL2
                    end
                end
                `CIOC_OF_LE: begin
                    if (eval) begin
                        out_r <= (count_value <= cmp_own); // RL3
                    end
                end
                `CIOC_OF_PULSE: begin
                    if (reach && dur != `CIOC_RST_PULSE) begin
                        out_r <= 1'b1; // RL4
                        left_r <= dur; // RL9
                    end else if (out_r && tick) begin
                        if (left_r <= 16'h0001) begin
                            out_r <= 1'b0; // RL4
                            left_r <= `CIOC_RST_PULSE;
                        end else begin
                            left_r <= left_r - 16'h0001; // RL9
                        end
                    end
                end
                `CIOC_OF_BETWEEN: begin
                    if (eval) begin
                        out_r <= in_range; // RL5
                    end
                end
                `CIOC_OF_SETCLR: begin
                    // a set and a reach in one cycle: the set wins
                    if (set_cmd) begin
                        out_r <= 1'b1; // RL6
                    end else if (reach) begin
                        out_r <= 1'b0; // RL6
                    end
                end
                `CIOC_OF_OUTSIDE: begin
                    if (eval) begin
                        out_r <= ~in_range; // RL7
                    end
                end
                default: begin
                    out_r <= 1'b0;
                end
            endcase
        end
    end

endmodule

// --------------------------------------------------------------
// top level
// --------------------------------------------------------------
// Functional notes
// [RL1] code 0000: output follows the user program level only
// [RL2] greater-or-equal mode: output high while count at or above comparison
// [RL3] less-or-equal mode: output high while count at or below comparison
// [RL4] code 0011: pulse of configured length when count hits comparison
// [RL5] code 0100: second output high between comparison values; reserved for first
// [RL6] code 0101: set by controller command, cleared when count hits comparison
// [RL7] code 0110: second output high outside comparison range; reserved for first
// [RL8] direction field: 01 forward, 10 backward, 11 both, 00 reserved
// [RL9] pulse length is 16-bit count of 0.1 ms units
// [RL10] input function 001 opens the gate on selected edge
// [RL11] input function 010 closes the gate on selected edge
// [RL12] input function 100 enables zero-mark synchronisation while input active
// [RL13] input function 101 captures counter value on selected edge
// [RL14] input function 110 is a plain reported input; 111 reserved
// [RL15] edge select: 01 rising, 10 falling, 11 both, 00 reserved
// [RL16] level select 0 means high active, 1 means low active
// [RL17] capture flag 1 reloads counter start value after capture
// [RL18] writes holding reserved codes are dropped, old settings kept
module cioc_top (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output wire [7:0] rdata,
    // counter core
    input wire [31:0] count_value,
    input wire count_up,
    input wire count_step,
    input wire [31:0] cmp_value0,
    input wire [31:0] cmp_value1,
    input wire zero_mark,
    // field signals
    input wire digital_input_first,
    output wire compare_output_first,
    output wire compare_output_second,
    // counter control
    output wire gate_level,
    output wire gate_open,
    output wire gate_close,
    output wire sync_strobe,
    output wire capture_strobe,
    output wire reload_strobe,
    output wire [31:0] capture_value
);

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    reg [7:0] out_func_r;
    reg [7:0] out_dir_r;
    reg [15:0] pulse0_r;
    reg [15:0] pulse1_r;
    reg [7:0] in_behav_r;
    reg [1:0] user_out_r;
    reg [1:0] set_cmd_r;
    reg [7:0] rdata_r;
    reg [31:0] cap_r;
    reg in_prev_r;
    reg gate_lvl_r;
    reg gate_open_r;
    reg gate_close_r;
    reg sync_r;
    reg cap_stb_r;
    reg reload_r;
    reg [`CIOC_TICK_W-1:0] tick_cnt_r;
    reg tick_r;

    // ----------------------------------------------------------
    // decoded fields
    // ----------------------------------------------------------
    wire wr_func_ok;
    wire wr_dir_ok;
    wire wr_in_ok;
    wire [2:0] in_func;
    wire [1:0] in_edge;
    wire in_act;
    wire rise;
    wire fall;
    wire edge_hit;
    wire [7:0] status;

    // first output refuses 0100 and 0110 up, second output 0111 up
    assign wr_func_ok = ((wdata[`CIOC_F_OF0] <= `CIOC_OF_PULSE) ||
                         (wdata[`CIOC_F_OF0] == `CIOC_OF_SETCLR)) &&
                        (wdata[`CIOC_F_OF1] <= `CIOC_OF_OUTSIDE); // RL18

    // direction 00 is reserved for either output
    assign wr_dir_ok = (wdata[`CIOC_F_DIR0] != `CIOC_DIR_RSVD) &&
                       (wdata[`CIOC_F_DIR1] != `CIOC_DIR_RSVD); // RL18

    // input function 111 and edge code 00 are reserved
    assign wr_in_ok = (wdata[`CIOC_F_IFUNC] != `CIOC_IF_RSVD) &&
                      (wdata[`CIOC_F_EDGE] != `CIOC_EDGE_RSVD); // RL18

    // input role, edge choice and polarity
    assign in_func = in_behav_r[`CIOC_F_IFUNC];
    assign in_edge = in_behav_r[`CIOC_F_EDGE];
    assign in_act = digital_input_first ^ in_behav_r[`CIOC_F_LVL]; // RL16
    assign rise = digital_input_first & ~in_prev_r;
    assign fall = ~digital_input_first & in_prev_r;
    assign edge_hit = (in_edge[`CIOC_E_RISE] & rise) |
                      (in_edge[`CIOC_E_FALL] & fall); // RL15

    // status byte: active input level and level gate
    assign status = {`CIOC_STAT_PAD, gate_lvl_r, in_act}; // RL14

    // ----------------------------------------------------------
    // parameter record
    // ----------------------------------------------------------
    // writes holding a reserved code are dropped as a whole byte
    always @(posedge clock) begin
        if (!rst_b) begin
            out_func_r <= `CIOC_RST_OUT_FUNC;
            out_dir_r <= `CIOC_RST_OUT_DIR;
            pulse0_r <= `CIOC_RST_PULSE;
            pulse1_r <= `CIOC_RST_PULSE;
            in_behav_r <= `CIOC_RST_IN_BEHAV;
            user_out_r <= `CIOC_RST_PAIR;
        end else if (wr) begin
            if (addr == `CIOC_OFS_OUT_FUNC) begin
                if (wr_func_ok) begin
                    out_func_r <= wdata; // RL18
                end
            end else if (addr == `CIOC_OFS_OUT_DIR) begin
                if (wr_dir_ok) begin
                    out_dir_r <= wdata; // RL8
                end
            end else if (addr == `CIOC_OFS_PULSE0_HI) begin
                pulse0_r[`CIOC_F_HI] <= wdata; // RL9
            end else if (addr == `CIOC_OFS_PULSE0_LO) begin
                pulse0_r[`CIOC_F_LO] <= wdata; // RL9
            end else if (addr == `CIOC_OFS_PULSE1_HI) begin
                pulse1_r[`CIOC_F_HI] <= wdata; // RL9
            end else if (addr == `CIOC_OFS_PULSE1_LO) begin
                pulse1_r[`CIOC_F_LO] <= wdata; // RL9
            end else if (addr == `CIOC_OFS_IN_BEHAV) begin
                if (wr_in_ok) begin
                    in_behav_r <= wdata; // RL14
                end
            end else if (addr == `CIOC_OFS_USER_OUT) begin
                user_out_r <= wdata[`CIOC_F_PAIR]; // RL1
            end
        end
    end

    // set command lasts one cycle per write to the command byte
    always @(posedge clock) begin
        if (!rst_b) begin
            set_cmd_r <= `CIOC_RST_PAIR;
        end else if (wr && addr == `CIOC_OFS_CMD) begin
            set_cmd_r <= wdata[`CIOC_F_PAIR]; // RL6
        end else begin
            set_cmd_r <= `CIOC_RST_PAIR;
        end
    end

    // ----------------------------------------------------------
    // pulse time base
    // ----------------------------------------------------------
    // one enable pulse every tenth of a millisecond
    always @(posedge clock) begin
        if (!rst_b) begin
            tick_cnt_r <= `CIOC_TICK_ZERO;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == `CIOC_TICK_LAST) begin
            tick_cnt_r <= `CIOC_TICK_ZERO;
            tick_r <= 1'b1; // RL9
        end else begin
            tick_cnt_r <= tick_cnt_r + `CIOC_TICK_ONE;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // compare outputs
    // ----------------------------------------------------------
    // first output: own comparison value 0
    cioc_chan ch0_u (
        .clock(clock),
        .rst_b(rst_b),
        .tick(tick_r),
        .func(out_func_r[`CIOC_F_OF0]),
        .dir(out_dir_r[`CIOC_F_DIR0]),
        .dur(pulse0_r),
        .user_lvl(user_out_r[`CIOC_F_SET0]),
        .set_cmd(set_cmd_r[`CIOC_F_SET0]),
        .count_value(count_value),
        .count_up(count_up),
        .count_step(count_step),
        .cmp_own(cmp_value0),
        .cmp_lo(cmp_value0),
        .cmp_hi(cmp_value1),
        .out_q(compare_output_first)
    );

    // second output: own comparison value 1, range from 0 to 1
    cioc_chan ch1_u (
        .clock(clock),
        .rst_b(rst_b),
        .tick(tick_r),
        .func(out_func_r[`CIOC_F_OF1]),
        .dir(out_dir_r[`CIOC_F_DIR1]),
        .dur(pulse1_r),
        .user_lvl(user_out_r[`CIOC_F_SET1]),
        .set_cmd(set_cmd_r[`CIOC_F_SET1]),
        .count_value(count_value),
        .count_up(count_up),
        .count_step(count_step),
        .cmp_own(cmp_value1),
        .cmp_lo(cmp_value0),
        .cmp_hi(cmp_value1),
        .out_q(compare_output_second)
    );

    // ----------------------------------------------------------
    // first digital input
    // ----------------------------------------------------------
    // the previous level is seeded from the pin so reset makes no edge
    always @(posedge clock) begin
        if (!rst_b) begin
            in_prev_r <= digital_input_first;
            gate_lvl_r <= 1'b0;
            gate_open_r <= 1'b0;
            gate_close_r <= 1'b0;
            sync_r <= 1'b0;
            cap_stb_r <= 1'b0;
            reload_r <= 1'b0;
            cap_r <= `CIOC_RST_WORD;
        end else begin
            in_prev_r <= digital_input_first;
            gate_lvl_r <= (in_func == `CIOC_IF_LEVEL) & in_act;
            gate_open_r <= (in_func == `CIOC_IF_GSTART) & edge_hit; // RL10
            gate_close_r <= (in_func == `CIOC_IF_GSTOP) & edge_hit; // RL11
            // zero mark only counts while the enable input is active
            sync_r <= ((in_func == `CIOC_IF_SYNC) & edge_hit) |
                      ((in_func == `CIOC_IF_SYNC_N) & in_act & zero_mark); // RL12
            cap_stb_r <= (in_func == `CIOC_IF_CAPTURE) & edge_hit; // RL13
            reload_r <= (in_func == `CIOC_IF_CAPTURE) & edge_hit &
                        in_behav_r[`CIOC_F_RELOAD]; // RL17
            if ((in_func == `CIOC_IF_CAPTURE) && edge_hit) begin
                cap_r <= count_value; // RL13
            end
        end
    end

    // ----------------------------------------------------------
    // register read
    // ----------------------------------------------------------
    // read data stand for one cycle after the read strobe
    always @(posedge clock) begin
        if (!rst_b) begin
            rdata_r <= `CIOC_RST_BYTE;
        end else if (!rd) begin
            rdata_r <= `CIOC_RST_BYTE;
        end else if (addr == `CIOC_OFS_OUT_FUNC) begin
            rdata_r <= out_func_r;
        end else if (addr == `CIOC_OFS_OUT_DIR) begin
            rdata_r <= out_dir_r;
        end else if (addr == `CIOC_OFS_PULSE0_HI) begin
            rdata_r <= pulse0_r[`CIOC_F_HI];
        end else if (addr == `CIOC_OFS_PULSE0_LO) begin
            rdata_r <= pulse0_r[`CIOC_F_LO];
        end else if (addr == `CIOC_OFS_PULSE1_HI) begin
            rdata_r <= pulse1_r[`CIOC_F_HI];
        end else if (addr == `CIOC_OFS_PULSE1_LO) begin
            rdata_r <= pulse1_r[`CIOC_F_LO];
        end else if (addr == `CIOC_OFS_IN_BEHAV) begin
            rdata_r <= in_behav_r;
        end else if (addr == `CIOC_OFS_USER_OUT) begin
            rdata_r <= {`CIOC_STAT_PAD, user_out_r};
        end else if (addr == `CIOC_OFS_STATUS) begin
            rdata_r <= status; // RL14
        end else if (addr == `CIOC_OFS_CAP_B3) begin
            rdata_r <= cap_r[`CIOC_F_B3];
        end else if (addr == `CIOC_OFS_CAP_B2) begin
            rdata_r <= cap_r[`CIOC_F_B2];
        end else if (addr == `CIOC_OFS_CAP_B1) begin
            rdata_r <= cap_r[`CIOC_F_B1];
        end else if (addr == `CIOC_OFS_CAP_B0) begin
            rdata_r <= cap_r[`CIOC_F_B0];
        end else begin
            rdata_r <= `CIOC_RST_BYTE;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    // every output comes straight from a flip-flop
    assign rdata = rdata_r;
    assign gate_level = gate_lvl_r;
    assign gate_open = gate_open_r;
    assign gate_close = gate_close_r;
    assign sync_strobe = sync_r;
    assign capture_strobe = cap_stb_r;
    assign reload_strobe = reload_r;
    assign capture_value = cap_r;

endmodule
`default_nettype wire

// >>> tb/cioc_chk.sv
// port checker for the counter i/o block
`timescale 1ns/10ps
`default_nettype none
module cioc_chk (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    // counter core
    input wire [31:0] count_value,
    input wire count_up,
    input wire [31:0] cmp_value0,
    // outputs
    input wire compare_output_first,
    input wire gate_open,
    input wire gate_close,
    input wire sync_strobe,
    input wire capture_strobe,
    input wire reload_strobe
);
    logic [7:0] of_r;
    logic [7:0] ib_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // shadow of the accepted function bytes, reserved codes dropped
    always @(posedge clock) begin
        if (!rst_b) begin
            of_r <= 8'h00;
            ib_r <= 8'h26;
        end else if (wr && addr == 8'h0A && wdata[3:0] < 4'h6 && wdata[3:0] != 4'h4
                     && wdata[7:4] < 4'h7) begin
            of_r <= wdata;
        end else if (wr && addr == 8'h10 && wdata[2:0] != 3'h7 && wdata[6:5] != 2'h0) begin
            ib_r <= wdata;
        end
    end
    AST_USER_HOLD: assert property ((of_r[3:0] == 4'h0 && !wr && !$past(wr)) |=>
        $stable(compare_output_first)) else $error("user output moved");
    AST_GE_HIGH: assert property ((of_r[3:0] == 4'h1 && count_up && count_value >= cmp_value0)[*3]
        |-> compare_output_first) else $error("ge output low");
    AST_LE_HIGH: assert property ((of_r[3:0] == 4'h2 && !count_up && count_value <= cmp_value0)[*3]
        |-> compare_output_first) else $error("le output low");
    AST_GATE_OPEN: assert property (gate_open |-> ib_r[2:0] == 3'h1) else $error("stray open");
    AST_GATE_CLOSE: assert property (gate_close |-> ib_r[2:0] == 3'h2) else $error("stray close");
    AST_SYNC_SRC: assert property (sync_strobe |-> ib_r[2:0] inside {3'h3, 3'h4}) else $error("stray sync");
    AST_CAPTURE_SRC: assert property (capture_strobe |-> ib_r[2:0] == 3'h5) else $error("stray capture");
    AST_RELOAD: assert property (reload_strobe |-> ib_r[7] && capture_strobe) else $error("stray reload");
    cover property (capture_strobe && ib_r[7]);
    cover property (gate_open);
    cover property (compare_output_first && of_r[3:0] == 4'h2);
endmodule
bind cioc_top cioc_chk chk_u (.clock, .rst_b, .addr, .wdata, .wr, .count_value, .count_up,
    .cmp_value0, .compare_output_first, .gate_open, .gate_close, .sync_strobe, .capture_strobe,
    .reload_strobe);
`default_nettype wire

// >>> tb/cioc_field.sv
// field side model: counter source and first digital input
`timescale 1ns/10ps
`default_nettype none
module cioc_field (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // bench control
    input wire logic dir_up,
    input wire logic in_lvl,
    // counter and field signals
    output logic [31:0] count_value,
    output logic count_up,
    output logic count_step,
    output logic zero_mark,
    output logic digital_input_first
);
    // counter steps once a cycle in the chosen direction
    always @(posedge clock) begin
        if (!rst_b) count_value <= 32'h0000_0000;
        else count_value <= dir_up ? count_value + 32'h1 : count_value - 32'h1;
    end
    assign count_up = dir_up;
    assign count_step = 1'b1;
    assign zero_mark = (count_value[3:0] == 4'h0);
    assign digital_input_first = in_lvl;
endmodule
`default_nettype wire

// >>> tb/counter_io_function_config_tb.sv
// self-checking bench for the counter i/o block
`timescale 1ns/10ps
`default_nettype none
module counter_io_function_config_tb;
    logic clock, rst_b, wr, rd, dir_up, in_lvl, seen;
    logic [7:0] addr, wdata;
    logic [31:0] cmp_value0, cmp_value1;
    wire [7:0] rdata;
    wire [31:0] count_value;
    wire count_up, count_step, zero_mark, digital_input_first, compare_output_first;
    wire compare_output_second, gate_open, gate_close, sync_strobe, capture_strobe, reload_strobe;
    wire [3:0] stb = {reload_strobe, capture_strobe, gate_close, gate_open};
    wire [31:0] cfgs = 32'hA525_2221;
    integer err_total = 0, num_checks = 0, k, n;
    cioc_top dut_u (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .count_value, .count_up,
        .count_step, .cmp_value0, .cmp_value1, .zero_mark, .digital_input_first,
        .compare_output_first, .compare_output_second, .gate_level(), .gate_open, .gate_close,
        .sync_strobe, .capture_strobe, .reload_strobe, .capture_value());
    cioc_field fld_u (.clock, .rst_b, .dir_up, .in_lvl, .count_value, .count_up, .count_step,
        .zero_mark, .digital_input_first);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
            @(posedge clock); wr <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        begin
            @(posedge clock); addr <= a; rd <= 1'b1;
            @(posedge clock); rd <= 1'b0;
            #1 chk("rdata", {24'h0, e}, {24'h0, rdata});
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        rst_b = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        dir_up = 1'b1; in_lvl = 1'b0; cmp_value0 = 32'd100; cmp_value1 = 32'd200;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        rchk(8'h0A, 8'h00);
        rchk(8'h0B, 8'hF0);
        rchk(8'h10, 8'h26);
        wreg(8'h0A, 8'h04); rchk(8'h0A, 8'h00);
        wreg(8'h0A, 8'h70); rchk(8'h0A, 8'h00);
        wreg(8'h0B, 8'h30); rchk(8'h0B, 8'hF0);
        wreg(8'h10, 8'h07); rchk(8'h10, 8'h26);
        wreg(8'h10, 8'h05); rchk(8'h10, 8'h26);
        wreg(8'h0A, 8'h11); repeat (120) @(posedge clock);
        #1 chk("ge_out", 1, compare_output_first);
        chk("ge_out1", 0, compare_output_second);
        dir_up <= 1'b0; wreg(8'h0A, 8'h22); repeat (100) @(posedge clock);
        #1 chk("le_out", 1, compare_output_first);
        chk("le_out1", 1, compare_output_second);
        wreg(8'h0A, 8'h00); dir_up <= 1'b1;
        // gate start, gate stop and capture, then capture with reload, must each raise their own strobe on a rising edge
        for (k = 0; k < 4; k = k + 1) begin
            wreg(8'h10, cfgs[8*k +: 8]); in_lvl <= 1'b0;
            repeat (3) @(posedge clock);
            in_lvl <= 1'b1; seen = 1'b0;
            for (n = 0; n < 8 && !seen; n = n + 1) begin
                @(posedge clock); #1 seen = stb[k];
            end
            chk("strobe", 1, {31'h0, seen});
            if (!seen) complete_run();
        end
        wreg(8'h10, 8'h26); rchk(8'h1A, 8'h01);
        wreg(8'h10, 8'h36); rchk(8'h1A, 8'h00);
        wreg(8'h10, 8'h20); rchk(8'h1A, 8'h03);
        wreg(8'h19, 8'h02); repeat (2) @(posedge clock);
        #1 chk("user_out", 32'h2, {compare_output_second, compare_output_first});
        cmp_value0 <= 32'h0000_0000; cmp_value1 <= 32'hFFFF_FFF0;
        wreg(8'h0A, 8'h40); repeat (2) @(posedge clock);
        #1 chk("between", 32'h2, {compare_output_second, compare_output_first});
        wreg(8'h0A, 8'h60); repeat (2) @(posedge clock);
        #1 chk("outside", 32'h0, {compare_output_second, compare_output_first});
        cmp_value0 <= 32'hFFFF_0000; cmp_value1 <= 32'hFFFF_0000;
        wreg(8'h0A, 8'h55); wreg(8'h18, 8'h03); repeat (2) @(posedge clock);
        #1 chk("set_out", 32'h3, {compare_output_second, compare_output_first});
        cmp_value0 <= count_value + 32'h8; cmp_value1 <= count_value + 32'h8;
        repeat (12) @(posedge clock);
        #1 chk("clr_out", 32'h0, {compare_output_second, compare_output_first});
        wreg(8'h0C, 8'h00); wreg(8'h0D, 8'h02); wreg(8'h0E, 8'h00); wreg(8'h0F, 8'h02);
        cmp_value0 <= count_value + 32'h10; cmp_value1 <= count_value + 32'h10;
        wreg(8'h0A, 8'h33); repeat (20) @(posedge clock);
        #1 chk("pulse_hi", 32'h3, {compare_output_second, compare_output_first});
        repeat (2010) @(posedge clock);
        #1 chk("pulse_lo", 32'h0, {compare_output_second, compare_output_first});
        complete_run();
    end
endmodule
`default_nettype wire
